// ==== inc/irq_pkg.sv ====
// Purpose: Constants and types for the vectored interrupt controller
// Assumes: Registers reached through an internal special-register port
// Notes:   Register selects, bit positions and vectors
// Behaviour
// - Events set their matching request flag
// - Per-source enable gates each request
// - Global enable low blocks all acceptance
// - Accept pushes next address, loads vector
// - Return pops saved address into counter
// - Accept clears global enable
// - Blocked requests keep their flags set
// - Full stack withholds acceptance
// - Requests sampled and served at phase two
// - Fixed priority ext0, ext1, timer, shared
// - Shared sub-sources use vector 18h
// - Service clears shared flag, not sub-flags
// - Main control register bit layout
// - Shared control register bit layout
// - Take needs flag, enables, stack room
// - Service clears external or timer flag
// - Two-bit edge select per external line
// - Shared flag set by enabled sub-source events or by a register write
package irq_pkg;
    // ----------------------------------------
    // Register selects and bit positions
    // ----------------------------------------
    localparam logic [1:0] SEL_MAIN      = 2'h0;
    localparam logic [1:0] SEL_SHARED    = 2'h1;
    localparam logic [1:0] SEL_TIMEBASE  = 2'h2;
    localparam logic [1:0] SEL_CMPMEM    = 2'h3;
    localparam int         B_GLOBAL_EN   = 0;
    localparam int         B_EXT0_EN     = 1;
    localparam int         B_EXT1_EN     = 2;
    localparam int         B_TIMER_EN    = 3;
    localparam int         B_EXT0_FLAG   = 4;
    localparam int         B_EXT1_FLAG   = 5;
    localparam int         B_TIMER_FLAG  = 6;
    localparam int         B_SHARED_EN   = 2;
    localparam int         B_SHARED_FLAG = 6;
    localparam int         B_TICK0_EN    = 1;
    localparam int         B_TICK1_EN    = 2;
    localparam int         B_TICK0_FLAG  = 5;
    localparam int         B_TICK1_FLAG  = 6;
    localparam int         B_CMP_EN      = 0;
    localparam int         B_MEM_EN      = 1;
    localparam int         B_CMP_FLAG    = 4;
    localparam int         B_MEM_FLAG    = 5;
    localparam logic [7:0] MAIN_MASK     = 8'h7f;
    localparam logic [7:0] SHARED_MASK   = 8'h44;
    localparam logic [7:0] TIMEBASE_MASK = 8'h66;
    localparam logic [7:0] CMPMEM_MASK   = 8'h33;
    localparam logic [7:0] REG_RESET     = 8'h00;
    // ----------------------------------------
    // Vectors and edge encodings
    // ----------------------------------------
    localparam logic [7:0] VEC_EXT0      = 8'h04;
    localparam logic [7:0] VEC_EXT1      = 8'h08;
    localparam logic [7:0] VEC_TIMER     = 8'h0c;
    localparam logic [7:0] VEC_SHARED    = 8'h18;
    localparam logic [1:0] EDGE_OFF      = 2'h0;
    localparam logic [1:0] EDGE_RISE     = 2'h1;
    localparam logic [1:0] EDGE_FALL     = 2'h2;
    localparam logic [1:0] EDGE_BOTH     = 2'h3;

    typedef struct packed {
        logic       wr;
        logic [1:0] sel;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] vector;
    } irq_take_s;
endpackage

// ==== rtl/priority_vectored_interrupts.sv ====
// Purpose: Latch, gate and prioritise interrupt requests for the core
// Assumes: Core pulses second_cycle_phase_i once per instruction cycle
// Notes:   Acceptance pulses take_o with vector; core pushes pc_next
`timescale 1ns/100ps
module priority_vectored_interrupts (
    // Clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 arst_n_i,
    // Core sequencer
    input  wire logic                 second_cycle_phase_i,
    input  wire logic                 return_from_irq_i,
    input  wire logic                 stack_full_i,
    input  wire logic [12:0]          pc_next_i,
    input  wire logic [12:0]          stack_top_i,
    output logic                      take_o,
    output logic [7:0]                vector_o,
    output logic                      push_o,
    output logic [12:0]               push_data_o,
    output logic                      pc_load_o,
    output logic [12:0]               pc_load_data_o,
    // Special register port
    input  wire irq_pkg::reg_req_s    reg_req_i,
    output logic [7:0]                reg_rdata_o,
    // Sources
    input  wire logic                 ext_line_0_i,
    input  wire logic                 ext_line_1_i,
    input  wire logic [3:0]           ext_edge_select_i,
    input  wire logic                 timer_ovf_i,
    input  wire logic                 tick0_i,
    input  wire logic                 tick1_i,
    input  wire logic                 comparator_event_i,
    input  wire logic                 memory_done_i
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0]        main_ff;
    logic [7:0]        shared_ff;
    logic [7:0]        tb_ff;
    logic [7:0]        cm_ff;
    logic [1:0]        ext_prev_ff;
    logic [1:0]        ext_hit;
    logic [3:0]        ready;
    logic              any_ready;
    irq_pkg::irq_take_s nxt_take;
    logic              accept;
    logic              wr_main;
    logic              wr_shared;
    logic              wr_tb;
    logic              wr_cm;
    logic [3:0]        sub_en;
    logic [3:0]        sub_flag;
    logic [3:0]        sub_set;

    function automatic logic edge_hit(input logic [1:0] mode, input logic prev,
                                      input logic cur);
        unique case (mode)
            irq_pkg::EDGE_RISE: edge_hit = !prev && cur;
            irq_pkg::EDGE_FALL: edge_hit = prev && !cur;
            irq_pkg::EDGE_BOTH: edge_hit = prev != cur;
            default:            edge_hit = 1'b0;
        endcase
    endfunction

    assign wr_main   = reg_req_i.wr && reg_req_i.sel == irq_pkg::SEL_MAIN;
    assign wr_shared = reg_req_i.wr && reg_req_i.sel == irq_pkg::SEL_SHARED;
    assign wr_tb     = reg_req_i.wr && reg_req_i.sel == irq_pkg::SEL_TIMEBASE;
    assign wr_cm     = reg_req_i.wr && reg_req_i.sel == irq_pkg::SEL_CMPMEM;

    // ----------------------------------------
    // Edge detect on external lines
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_prev_ff <= 2'h0;
        end else begin
            ext_prev_ff <= {ext_line_1_i, ext_line_0_i};
        end
    end
    assign ext_hit[0] = edge_hit(ext_edge_select_i[1:0], ext_prev_ff[0], ext_line_0_i);
    assign ext_hit[1] = edge_hit(ext_edge_select_i[3:2], ext_prev_ff[1], ext_line_1_i);

    // ----------------------------------------
    // Priority and acceptance
    // ----------------------------------------
    assign ready[0] = main_ff[irq_pkg::B_EXT0_FLAG] && main_ff[irq_pkg::B_EXT0_EN];
    assign ready[1] = main_ff[irq_pkg::B_EXT1_FLAG] && main_ff[irq_pkg::B_EXT1_EN];
    assign ready[2] = main_ff[irq_pkg::B_TIMER_FLAG] && main_ff[irq_pkg::B_TIMER_EN];
    assign ready[3] = shared_ff[irq_pkg::B_SHARED_FLAG] && shared_ff[irq_pkg::B_SHARED_EN];
    assign any_ready = |ready;
    // Sampled only at phase two, gated by global enable and stack room
    assign accept = second_cycle_phase_i && any_ready && main_ff[irq_pkg::B_GLOBAL_EN]
                    && !stack_full_i && !take_o;

    always_comb begin
        nxt_take.valid  = accept;
        nxt_take.vector = irq_pkg::VEC_SHARED;
        if (ready[0]) begin
            nxt_take.vector = irq_pkg::VEC_EXT0;
        end else if (ready[1]) begin
            nxt_take.vector = irq_pkg::VEC_EXT1;
        end else if (ready[2]) begin
            nxt_take.vector = irq_pkg::VEC_TIMER;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            take_o         <= 1'b0;
            vector_o       <= 8'h00;
            push_o         <= 1'b0;
            push_data_o    <= 13'h0000;
            pc_load_o      <= 1'b0;
            pc_load_data_o <= 13'h0000;
        end else begin
            take_o      <= nxt_take.valid;
            vector_o    <= nxt_take.valid ? nxt_take.vector : vector_o;
            push_o      <= nxt_take.valid;
            push_data_o <= nxt_take.valid ? pc_next_i : push_data_o;
            pc_load_o   <= nxt_take.valid || return_from_irq_i;
            if (nxt_take.valid) begin
                pc_load_data_o <= {5'h00, nxt_take.vector};
            end else if (return_from_irq_i) begin
                pc_load_data_o <= stack_top_i;
            end
        end
    end

    // ----------------------------------------
    // Main control register
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            main_ff <= irq_pkg::REG_RESET;
        end else begin
            logic [7:0] v;
            v = wr_main ? (reg_req_i.wdata & irq_pkg::MAIN_MASK) : main_ff;
            if (accept) begin
                v[irq_pkg::B_GLOBAL_EN] = 1'b0;
                if (ready[0]) begin
                    v[irq_pkg::B_EXT0_FLAG] = 1'b0;
                end else if (ready[1]) begin
                    v[irq_pkg::B_EXT1_FLAG] = 1'b0;
                end else if (ready[2]) begin
                    v[irq_pkg::B_TIMER_FLAG] = 1'b0;
                end
            end
            // Events win over clears and keep flags while blocked
            if (ext_hit[0]) v[irq_pkg::B_EXT0_FLAG] = 1'b1;
            if (ext_hit[1]) v[irq_pkg::B_EXT1_FLAG] = 1'b1;
            if (timer_ovf_i) v[irq_pkg::B_TIMER_FLAG] = 1'b1;
            main_ff <= v;
        end
    end

    // ----------------------------------------
    // Sub-source registers
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tb_ff <= irq_pkg::REG_RESET;
            cm_ff <= irq_pkg::REG_RESET;
        end else begin
            logic [7:0] t;
            logic [7:0] c;
            t = wr_tb ? (reg_req_i.wdata & irq_pkg::TIMEBASE_MASK) : tb_ff;
            c = wr_cm ? (reg_req_i.wdata & irq_pkg::CMPMEM_MASK) : cm_ff;
            if (tick0_i) t[irq_pkg::B_TICK0_FLAG] = 1'b1;
            if (tick1_i) t[irq_pkg::B_TICK1_FLAG] = 1'b1;
            if (comparator_event_i) c[irq_pkg::B_CMP_FLAG] = 1'b1;
            if (memory_done_i) c[irq_pkg::B_MEM_FLAG] = 1'b1;
            tb_ff <= t;
            cm_ff <= c;
        end
    end

    // ----------------------------------------
    // Shared control register
    // ----------------------------------------
    assign sub_en   = {cm_ff[irq_pkg::B_MEM_EN], cm_ff[irq_pkg::B_CMP_EN],
                       tb_ff[irq_pkg::B_TICK1_EN], tb_ff[irq_pkg::B_TICK0_EN]};
    assign sub_flag = {memory_done_i, comparator_event_i, tick1_i, tick0_i};
    assign sub_set  = sub_en & sub_flag;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shared_ff <= irq_pkg::REG_RESET;
        end else begin
            logic [7:0] s;
            s = wr_shared ? (reg_req_i.wdata & irq_pkg::SHARED_MASK) : shared_ff;
            if (accept && ready == 4'h8) begin
                s[irq_pkg::B_SHARED_FLAG] = 1'b0;
            end
            if (|sub_set) s[irq_pkg::B_SHARED_FLAG] = 1'b1;
            shared_ff <= s;
        end
    end

    // ----------------------------------------
    // Read back
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            unique case (reg_req_i.sel)
                irq_pkg::SEL_MAIN:     reg_rdata_o <= main_ff;
                irq_pkg::SEL_SHARED:   reg_rdata_o <= shared_ff;
                irq_pkg::SEL_TIMEBASE: reg_rdata_o <= tb_ff;
                irq_pkg::SEL_CMPMEM:   reg_rdata_o <= cm_ff;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_take_clears_global: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        take_o |-> !main_ff[irq_pkg::B_GLOBAL_EN])
        else $error("global enable not cleared on accept");
    a_no_take_disabled: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !main_ff[irq_pkg::B_GLOBAL_EN] |=> !take_o)
        else $error("interrupt taken while globally disabled");
    a_stack_full_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        stack_full_i |=> !take_o)
        else $error("interrupt taken with full stack");
    a_phase_only_take: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        take_o |-> $past(second_cycle_phase_i))
        else $error("interrupt taken outside phase two");
    a_ext0_first_vec: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        accept && ready[0] |=> vector_o == irq_pkg::VEC_EXT0)
        else $error("external 0 lost priority");
    a_push_pc_next: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        accept |=> push_o && push_data_o == $past(pc_next_i) && pc_load_o)
        else $error("push or vector load missing");
    a_return_from_irq_pop: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        return_from_irq_i && !accept |=> pc_load_o && pc_load_data_o == $past(stack_top_i))
        else $error("return did not restore address");
    a_timer_flag_set: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        timer_ovf_i |=> main_ff[irq_pkg::B_TIMER_FLAG])
        else $error("timer flag not set");
    a_disabled_not_taken: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        accept && !main_ff[irq_pkg::B_EXT0_EN] |=> vector_o != irq_pkg::VEC_EXT0)
        else $error("disabled source taken");
endmodule

// ==== tb/core_model.sv ====
// Purpose: Core sequencer stand-in: phase pulses and return stack
// Assumes: Pushes and pops never share a cycle
// Notes:   Empty stack shows a changing pattern on its top output
`timescale 1ns/100ps
module core_model #(
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Stack traffic
    input  wire logic        push_i,
    input  wire logic        pop_i,
    input  wire logic [12:0] push_data_i,
    // Core outputs
    output logic             phase_o,
    output logic             full_o,
    output logic [12:0]      top_o
);
    logic [1:0]  div_ff;
    int          depth_ff;
    logic [12:0] mem_ff [0:3];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) div_ff <= 2'h0;
        else div_ff <= div_ff + 2'h1;
    end
    assign phase_o = (div_ff == 2'h3);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) depth_ff <= 0;
        else if (push_i) begin
            mem_ff[depth_ff] <= push_data_i;
            depth_ff         <= depth_ff + 1;
        end else if (pop_i && depth_ff > 0) depth_ff <= depth_ff - 1;
    end
    assign full_o = (depth_ff >= DEPTH);
    assign top_o  = (depth_ff > 0) ? mem_ff[depth_ff - 1] : {13{div_ff[0]}};
endmodule

// ==== tb/priority_vectored_interrupts_tb_top.sv ====
// Purpose: Self-checking bench for the vectored interrupt controller
// Assumes: Stack of two entries held by the core model
// Notes:   Bench keeps its own register and stack picture
`timescale 1ns/100ps
module priority_vectored_interrupts_tb_top;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic ph, full, rq = 1'b0, take_o, push_o, pc_load_o;
    logic [12:0] pc = 13'h0, top, push_data_o, pc_load_data_o;
    logic [7:0] vector_o, reg_rdata_o, m;
    logic [4:0] ev = 5'h0;
    logic [1:0] ln = 2'h0;
    logic [3:0] esel = 4'h0;
    irq_pkg::reg_req_s req = '0;
    logic [12:0] pcq[$];
    logic [7:0] vec[4] = '{8'h04, 8'h08, 8'h0c, 8'h18};
    logic [7:0] clr[4] = '{8'h10, 8'h20, 8'h40, 8'h00};
    logic [1:0] es[5] = '{2'h0, 2'h2, 2'h2, 2'h3, 2'h3};
    logic [7:0] eb[5] = '{8'h4e, 8'h20, 8'h40, 8'h10, 8'h20};
    logic [7:0] msk[4];
    integer seed = 32'h6508;
    int n_errors = 0;
    int check_count = 0;

    always #25 sys_clk_i = ~sys_clk_i;
    core_model #(.DEPTH(2)) partner (.clk_i(sys_clk_i), .rst_n_i(arst_n_i), .push_i(push_o),
        .pop_i(rq), .push_data_i(push_data_o), .phase_o(ph), .full_o(full), .top_o(top));
    priority_vectored_interrupts DUT (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .second_cycle_phase_i(ph), .return_from_irq_i(rq), .stack_full_i(full),
        .pc_next_i(pc), .stack_top_i(top), .take_o(take_o), .vector_o(vector_o),
        .push_o(push_o), .push_data_o(push_data_o), .pc_load_o(pc_load_o),
        .pc_load_data_o(pc_load_data_o), .reg_req_i(req), .reg_rdata_o(reg_rdata_o),
        .ext_line_0_i(ln[0]), .ext_line_1_i(ln[1]), .ext_edge_select_i(esel),
        .timer_ovf_i(ev[0]), .tick0_i(ev[1]), .tick1_i(ev[2]),
        .comparator_event_i(ev[3]), .memory_done_i(ev[4]));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic complete_run();
        if (n_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input int s, input logic [7:0] d);
        @(posedge sys_clk_i);
        req <= '{wr: 1'b1, sel: 2'(s), wdata: d};
        pc  <= 13'($random(seed));
        @(posedge sys_clk_i);
        req <= '{wr: 1'b0, sel: 2'(s), wdata: 8'h00};
    endtask
    task automatic rd(input int s, input logic [7:0] e);
        @(posedge sys_clk_i);
        req <= '{wr: 1'b0, sel: 2'(s), wdata: 8'h00};
        @(posedge sys_clk_i);
        #1 chk({5'h0, reg_rdata_o}, {5'h0, e});
    endtask
    task automatic take(input logic [7:0] v);
        for (int n = 0; n < 16 && take_o !== 1'b1; n++) @(posedge sys_clk_i) #1;
        pcq.push_back(pc);
        chk({12'h0, take_o}, 13'h1);
        chk({12'h0, push_o}, 13'h1);
        chk({12'h0, pc_load_o}, 13'h1);
        chk({5'h0, vector_o}, {5'h0, v});
        chk(push_data_o, pc);
        chk(pc_load_data_o, {5'h0, v});
    endtask
    task automatic none();
        repeat (12) @(posedge sys_clk_i) #1 chk({12'h0, take_o}, 13'h0);
    endtask
    task automatic ret();
        @(posedge sys_clk_i) rq <= 1'b1;
        @(posedge sys_clk_i) rq <= 1'b0;
        #1 chk({12'h0, pc_load_o}, 13'h1);
        chk(pc_load_data_o, pcq.pop_back());
    endtask

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_errors++;
        complete_run();
    end
    initial begin
        msk = '{irq_pkg::MAIN_MASK, irq_pkg::SHARED_MASK, irq_pkg::TIMEBASE_MASK,
                irq_pkg::CMPMEM_MASK};
        repeat (4) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            rd(2'(s), irq_pkg::REG_RESET);
            wr(2'(s), (s == 0) ? 8'hfe : 8'hff);
            rd(2'(s), msk[s] & ((s == 0) ? 8'hfe : 8'hff));
            wr(2'(s), 8'h00);
        end
        wr(0, 8'h7e);
        wr(1, 8'h40);
        none();
        wr(0, 8'h71);
        none();
        rd(0, 8'h71);
        wr(0, 8'h70);
        wr(1, 8'h44);
        m = 8'h7e;
        for (int i = 0; i < 4; i++) begin
            wr(0, m | 8'h01);
            if (i == 2) none();
            if (i >= 2) ret();
            take(vec[i]);
            m = m & ~clr[i];
            rd(0, m);
        end
        rd(1, 8'h04);
        ret();
        ret();
        for (int k = 0; k < 5; k++) begin
            @(posedge sys_clk_i) ev <= 5'(1 << k);
            @(posedge sys_clk_i) ev <= 5'h0;
            rd(es[k], eb[k]);
            wr(es[k], 8'h00);
        end
        rd(1, 8'h04);
        wr(2, 8'h02);
        @(posedge sys_clk_i) ev <= 5'h02;
        @(posedge sys_clk_i) ev <= 5'h00;
        rd(1, 8'h44);
        wr(0, 8'h01);
        take(8'h18);
        rd(1, 8'h04);
        rd(2, 8'h22);
        wr(2, 8'h02);
        rd(2, 8'h02);
        ret();
        for (int md = 0; md < 4; md++) begin
            @(posedge sys_clk_i) esel <= {2'(md), 2'(md)};
            wr(0, 8'h00);
            @(posedge sys_clk_i) ln <= 2'h3;
            repeat (3) @(posedge sys_clk_i);
            rd(0, md[0] ? 8'h30 : 8'h00);
            wr(0, 8'h00);
            @(posedge sys_clk_i) ln <= 2'h0;
            repeat (3) @(posedge sys_clk_i);
            rd(0, md[1] ? 8'h30 : 8'h00);
        end
        complete_run();
    end
endmodule
